// file: rtl/quad_pumped_data_bus_inversion.sv
// quad-pumped 64-bit data bus endpoint with per-group inversion
// Functional notes
// - four sub-phases each common clock period
// - capture on alternating falling strobe edges
// - each 16-bit group has own strobe pair
// - one inversion flag per 16-bit group
// - flags travel and apply with data
// - flag asserted exactly when group complemented
// - invert when nine or more lines low
// - busy line low while driving data
`timescale 1ns/100ps
module quad_pumped_data_bus_inversion
	import qp_dbi_pkg::*;
(
	input  wire logic                 CORE_CLK,
	input  wire logic                 RSTN,
	input  wire logic                 TX_VALID,
	output logic                      TX_READY,
	input  wire logic [BEAT_W-1:0]    TX_DATA,
	input  wire logic                 TX_INV_EN,
	output logic                      RX_VALID,
	output logic      [BEAT_W-1:0]    RX_DATA,
	output logic      [FLAGS_W-1:0]   RX_FLAGS,
	input  wire logic [DATA_W-1:0]    DATA_N_I,
	output logic      [DATA_W-1:0]    DATA_N_O,
	output logic                      DATA_N_OE,
	input  wire logic [GROUPS-1:0]    GROUP_INVERT_FLAG_N_I,
	output logic      [GROUPS-1:0]    GROUP_INVERT_FLAG_N_O,
	output logic                      GROUP_INVERT_FLAG_N_OE,
	input  wire logic [GROUPS-1:0]    DATA_STROBE_POS_N_I,
	input  wire logic [GROUPS-1:0]    DATA_STROBE_NEG_N_I,
	output logic      [GROUPS-1:0]    DATA_STROBE_POS_N_O,
	output logic      [GROUPS-1:0]    DATA_STROBE_NEG_N_O,
	output logic                      DATA_STROBE_N_OE,
	input  wire logic                 DATA_LINES_IN_USE_N_I,
	output logic                      DATA_LINES_IN_USE_N_O,
	output logic                      DATA_LINES_IN_USE_N_OE,
	output logic                      COMMON_CLK_O
);

	generate
		if (CYCLES_PER_COMMON != SUBPHASES * CYCLES_PER_SUB ||
		    CYCLES_PER_COMMON != (1 << CNT_W) ||
		    CYCLES_PER_SUB != 2) begin : g_bad_timing
			$error("core clock cannot pace four sub-phases per period");
		end
	endgenerate

	function automatic logic [4:0] ones_count(input logic [GROUP_W-1:0] d);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < GROUP_W; i++) begin
			n = 5'(n + {4'h0, d[i]});
		end
		return n;
	endfunction : ones_count

	// returns {flag_n, pin levels}; true ones are driven low unless the group is inverted
	function automatic logic [LANE_W-1:0] encode_group(
		input logic [GROUP_W-1:0] d,
		input logic               en
	);
		logic inv;
		inv = en && (ones_count(d) > INV_THRESHOLD);
		return {~inv, (inv ? d : ~d)};
	endfunction : encode_group

	function automatic logic [GROUP_W-1:0] decode_group(
		input logic [GROUP_W-1:0] pins,
		input logic               flag_n
	);
		return flag_n ? ~pins : pins;
	endfunction : decode_group

	tx_state_t            state;
	tx_state_t            next_state;
	logic [CNT_W-1:0]     cnt;
	logic [BEAT_W-1:0]    beat_pins;
	logic [FLAGS_W-1:0]   beat_flags;
	logic                 drv;
	logic                 busy_meta;
	logic                 busy_sync;
	logic [3:0]           echo_cnt;
	logic [GROUPS-1:0]    tgl_meta;
	logic [GROUPS-1:0]    tgl_sync;
	logic [GROUPS-1:0]    tgl_last;

	wire  [BEAT_W-1:0]    enc_pins;
	wire  [FLAGS_W-1:0]   enc_flags;
	wire  [BEAT_W-1:0]    dec_data;
	wire  [FLAGS_W-1:0]   dec_flags;
	wire  [HOLD_W-1:0]    group_hold [GROUPS];
	wire  [GROUPS-1:0]    group_tgl;

	wire                  period_end;
	wire                  bus_free;
	wire                  take;
	wire                  finish;
	wire                  odd_cycle;
	wire  [1:0]           next_idx;
	wire  [DATA_W-1:0]    next_word;
	wire  [GROUPS-1:0]    next_flags;
	wire                  rx_arrived;
	wire                  own_echo;
	wire  [CNT_W-1:0]     next_cnt;

	assign next_cnt   = CNT_W'(cnt + 3'h1);
	assign period_end = (cnt == CNT_LAST);
	// other agent releases the data lines by raising its busy line
	assign bus_free   = busy_sync;
	// beats start on a common period
	assign TX_READY   = period_end && ((state == TX_SEND) || bus_free);
	assign take       = TX_VALID && TX_READY;
	assign finish     = period_end && (state == TX_SEND) && !take;
	assign odd_cycle  = cnt[0];
	assign next_idx   = 2'(cnt[2:1] + 2'h1);
	assign next_word  = beat_pins[next_idx*DATA_W +: DATA_W];
	assign next_flags = beat_flags[next_idx*GROUPS +: GROUPS];

	genvar k, g;
	generate
		for (k = 0; k < SUBPHASES; k++) begin : g_sub
			for (g = 0; g < GROUPS; g++) begin : g_grp
				localparam int B = k * DATA_W + g * GROUP_W;
				wire [LANE_W-1:0] lane = encode_group(
					TX_DATA[B +: GROUP_W], TX_INV_EN);
				assign enc_pins[B +: GROUP_W]  = lane[GROUP_W-1:0];
				assign enc_flags[k*GROUPS + g] = lane[GROUP_W];
				wire [LANE_W-1:0] cap =
					group_hold[g][k*LANE_W +: LANE_W];
				assign dec_data[B +: GROUP_W] =
					decode_group(cap[GROUP_W-1:0], cap[GROUP_W]);
				assign dec_flags[k*GROUPS + g] = ~cap[GROUP_W];
			end
		end
		for (g = 0; g < GROUPS; g++) begin : g_cap
			// group g on strobe pair g
			strobe_group_capture u_cap (
				.strobe_pos_n (DATA_STROBE_POS_N_I[g]),
				.strobe_neg_n (DATA_STROBE_NEG_N_I[g]),
				.rstn         (RSTN),
				.data_n       (DATA_N_I[g*GROUP_W +: GROUP_W]),
				.flag_n       (GROUP_INVERT_FLAG_N_I[g]),
				.hold         (group_hold[g]),
				.beat_toggle  (group_tgl[g])
			);
		end
	endgenerate

	always_comb begin
		next_state = state;
		case (state)
			TX_IDLE: begin
				if (take)
					next_state = TX_SEND;
			end
			TX_SEND: begin
				if (finish)
					next_state = TX_IDLE;
			end
			default: begin
				next_state = TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state        <= TX_IDLE;
			cnt          <= CNT_LAST;
			COMMON_CLK_O <= 1'b0;
		end else begin
			state        <= next_state;
			cnt          <= next_cnt;
			COMMON_CLK_O <= (next_cnt < CNT_HALF);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			beat_pins  <= '0;
			beat_flags <= '1;
		end else if (take) begin
			beat_pins  <= enc_pins;
			beat_flags <= enc_flags;
		end
	end

	// data changes one cycle ahead of each strobe edge for setup margin
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			DATA_N_O              <= '1;
			GROUP_INVERT_FLAG_N_O <= '1;
			DATA_STROBE_POS_N_O   <= '1;
			DATA_STROBE_NEG_N_O   <= '1;
			drv                   <= 1'b0;
			DATA_LINES_IN_USE_N_O <= 1'b1;
		end else if (take) begin
			DATA_N_O              <= enc_pins[DATA_W-1:0];
			GROUP_INVERT_FLAG_N_O <= enc_flags[GROUPS-1:0];
			DATA_STROBE_NEG_N_O   <= '1;
			drv                   <= 1'b1;
			DATA_LINES_IN_USE_N_O <= 1'b0;
		end else if (finish) begin
			DATA_STROBE_POS_N_O   <= '1;
			DATA_STROBE_NEG_N_O   <= '1;
			drv                   <= 1'b0;
			DATA_LINES_IN_USE_N_O <= 1'b1;
		end else if (state == TX_SEND) begin
			if (odd_cycle) begin
				DATA_N_O              <= next_word;
				GROUP_INVERT_FLAG_N_O <= next_flags;
			end else begin
				DATA_STROBE_POS_N_O <= {GROUPS{cnt[1]}};
				DATA_STROBE_NEG_N_O <= {GROUPS{~cnt[1]}};
			end
		end
	end

	assign DATA_N_OE              = drv;
	assign GROUP_INVERT_FLAG_N_OE = drv;
	assign DATA_STROBE_N_OE       = drv;
	assign DATA_LINES_IN_USE_N_OE = drv;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			busy_meta <= 1'b1;
			busy_sync <= 1'b1;
			tgl_meta  <= '0;
			tgl_sync  <= '0;
		end else begin
			busy_meta <= DATA_LINES_IN_USE_N_I;
			busy_sync <= busy_meta;
			tgl_meta  <= group_tgl;
			tgl_sync  <= tgl_meta;
		end
	end

	// our own beats echo back through the capture path; drop them
	assign own_echo   = drv || (echo_cnt != 4'h0);
	assign rx_arrived = &(tgl_sync ^ tgl_last);

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			echo_cnt <= 4'h0;
		end else if (drv) begin
			echo_cnt <= ECHO_GUARD;
		end else if (echo_cnt != 4'h0) begin
			echo_cnt <= 4'(echo_cnt - 4'h1);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tgl_last <= '0;
			RX_VALID <= 1'b0;
			RX_DATA  <= '0;
			RX_FLAGS <= '0;
		end else begin
			RX_VALID <= rx_arrived && !own_echo;
			if (rx_arrived) begin
				tgl_last <= tgl_sync;
			end
			if (rx_arrived && !own_echo) begin
				RX_DATA  <= dec_data;
				RX_FLAGS <= dec_flags;
			end
		end
	end

endmodule : quad_pumped_data_bus_inversion

// file: include/qp_dbi_pkg.sv
// constants and types for the quad-pumped data bus with group inversion
package qp_dbi_pkg;

	localparam int DATA_W          = 64;
	localparam int GROUPS          = 4;
	localparam int GROUP_W         = 16;
	localparam int SUBPHASES       = 4;
	localparam int BEAT_W          = DATA_W * SUBPHASES;
	localparam int FLAGS_W         = GROUPS * SUBPHASES;
	localparam int LANE_W          = GROUP_W + 1;
	localparam int HOLD_W          = LANE_W * SUBPHASES;

	// inversion pays off once more than half of a group would sit low
	localparam logic [4:0] INV_THRESHOLD = 5'h08;

	localparam int CORE_PERIOD_NS   = 20;
	localparam int COMMON_PERIOD_NS = 160;
	localparam int CYCLES_PER_COMMON = COMMON_PERIOD_NS / CORE_PERIOD_NS;
	localparam int CYCLES_PER_SUB   = CYCLES_PER_COMMON / SUBPHASES;

	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] CNT_LAST  = 3'h7;
	localparam logic [CNT_W-1:0] CNT_HALF  = 3'h4;
	localparam logic [3:0]       ECHO_GUARD = 4'h8;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} tx_state_t;

endpackage : qp_dbi_pkg

// file: rtl/strobe_group_capture.sv
// capture of one 16-bit group and its flag on its own strobe pair
`timescale 1ns/100ps
module strobe_group_capture
	import qp_dbi_pkg::*;
(
	input  wire logic                 strobe_pos_n,
	input  wire logic                 strobe_neg_n,
	input  wire logic                 rstn,
	input  wire logic [GROUP_W-1:0]   data_n,
	input  wire logic                 flag_n,
	output logic      [HOLD_W-1:0]    hold,
	output logic                      beat_toggle
);

	logic               pos_ptr;
	logic               neg_ptr;
	logic [LANE_W-1:0]  sub0;
	logic [LANE_W-1:0]  sub1;
	logic [LANE_W-1:0]  sub2;

	always_ff @(negedge strobe_pos_n or negedge rstn) begin
		if (!rstn) begin
			pos_ptr <= 1'b0;
			sub0    <= '0;
			sub2    <= '0;
		end else begin
			pos_ptr <= ~pos_ptr;
			if (!pos_ptr)
				sub0 <= {flag_n, data_n};
			else
				sub2 <= {flag_n, data_n};
		end
	end

	// negative strobe edges
	// sub0 and sub2 are read here safely: they settled a strobe edge earlier
	always_ff @(negedge strobe_neg_n or negedge rstn) begin
		if (!rstn) begin
			neg_ptr     <= 1'b0;
			sub1        <= '0;
			hold        <= '0;
			beat_toggle <= 1'b0;
		end else begin
			neg_ptr <= ~neg_ptr;
			if (!neg_ptr) begin
				sub1 <= {flag_n, data_n};
			end else begin
				hold        <= {flag_n, data_n, sub2, sub1, sub0};
				beat_toggle <= ~beat_toggle;
			end
		end
	end

endmodule : strobe_group_capture

// file: dv/qp_dbi_props.sv
// assertions on the pins of the quad-pumped bus endpoint
`timescale 1ns/100ps
module qp_dbi_props
	import qp_dbi_pkg::*;
(
	input wire logic              CORE_CLK,
	input wire logic              RSTN,
	input wire logic              TX_VALID,
	input wire logic              TX_READY,
	input wire logic [BEAT_W-1:0] TX_DATA,
	input wire logic              TX_INV_EN,
	input wire logic              RX_VALID,
	input wire logic [DATA_W-1:0] DATA_N_O,
	input wire logic              DATA_N_OE,
	input wire logic [GROUPS-1:0] GROUP_INVERT_FLAG_N_O,
	input wire logic              GROUP_INVERT_FLAG_N_OE,
	input wire logic [GROUPS-1:0] DATA_STROBE_POS_N_O,
	input wire logic [GROUPS-1:0] DATA_STROBE_NEG_N_O,
	input wire logic              DATA_STROBE_N_OE,
	input wire logic              DATA_LINES_IN_USE_N_O,
	input wire logic              DATA_LINES_IN_USE_N_OE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	logic [BEAT_W-1:0] beat;
	logic              inv;
	wire               take = TX_VALID && TX_READY;
	wire  [3:0]        fo = GROUP_INVERT_FLAG_N_O;
	// beat kept so each later sub-phase can be judged
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			beat <= '0;
			inv  <= 1'b0;
		end else if (take) begin
			beat <= TX_DATA;
			inv  <= TX_INV_EN;
		end
	end
	function automatic logic [3:0] exp_flags(input int k);
		for (int g = 0; g < 4; g++)
			exp_flags[g] = !(inv && $countones(beat[64*k+16*g+:16]) > 8);
	endfunction : exp_flags
	function automatic logic [63:0] exp_pins(input int k);
		logic [3:0] f;
		f = exp_flags(k);
		for (int g = 0; g < 4; g++)
			exp_pins[16*g+:16] = f[g] ? ~beat[64*k+16*g+:16]
				: beat[64*k+16*g+:16];
	endfunction : exp_pins
	a_words_in_order:
	assert property (take |=> DATA_N_O == exp_pins(0) ##2
		DATA_N_O == exp_pins(1) ##2 DATA_N_O == exp_pins(2) ##2
		DATA_N_O == exp_pins(3)) else $error("sub-phase word wrong");
	a_flag_choice:
	assert property (take |=> fo == exp_flags(0) ##2 fo == exp_flags(1)
		##2 fo == exp_flags(2) ##2 fo == exp_flags(3))
		else $error("inversion flag wrong");
	a_drive_span:
	assert property (take |=> DATA_N_OE [*8]) else $error("drive too short");
	a_busy_while_driving:
	assert property (DATA_N_OE |-> !DATA_LINES_IN_USE_N_O
		&& DATA_LINES_IN_USE_N_OE) else $error("busy not shown");
	a_flags_with_data:
	assert property (DATA_N_OE |-> GROUP_INVERT_FLAG_N_OE && DATA_STROBE_N_OE)
		else $error("flags or strobes not driven");
	a_ready_spacing:
	assert property (TX_READY |=> !TX_READY [*7]) else $error("ready spacing");
	a_strobe_turns:
	assert property ($fell(DATA_STROBE_POS_N_O[0]) |-> ##2
		$fell(DATA_STROBE_NEG_N_O[0])) else $error("strobes not alternating");
	a_rx_single:
	assert property (RX_VALID |=> !RX_VALID) else $error("rx valid too long");
	c_take: cover property (take);
	c_take_inv: cover property (take && TX_INV_EN);
	c_rx: cover property (RX_VALID);
endmodule : qp_dbi_props

bind quad_pumped_data_bus_inversion qp_dbi_props props_u (.*);

// file: dv/far_agent_model.sv
// far-side bus agent: drives and takes quad-pumped beats
`timescale 1ns/100ps
module far_agent_model (
	input  wire logic [63:0] data_n,
	input  wire logic [3:0]  flag_n,
	input  wire logic [3:0]  pos_n,
	input  wire logic [3:0]  neg_n,
	output logic      [63:0] far_data_n,
	output logic      [3:0]  far_flag_n,
	output logic      [3:0]  far_pos_n,
	output logic      [3:0]  far_neg_n,
	output logic             far_busy_n,
	output logic             far_oe
);
	logic [255:0] got [$];
	logic [15:0]  gflags [$];
	logic [255:0] acc;
	logic [15:0]  facc;
	int           idx = 0;
	initial begin
		far_oe = 1'b0;
		far_busy_n = 1'b1;
		far_pos_n = '1;
		far_neg_n = '1;
		far_data_n = '1;
		far_flag_n = '1;
	end
	// alternate strobe falls, undo flagged groups
	always @(negedge pos_n[0] or negedge neg_n[0]) begin
		if (!far_oe) begin
			for (int g = 0; g < 4; g++) begin
				acc[64*idx+16*g+:16] = flag_n[g] ? ~data_n[16*g+:16]
					: data_n[16*g+:16];
				facc[4*idx+g] = !flag_n[g];
			end
			idx = (idx + 1) % 4;
			if (idx == 0) begin
				got.push_back(acc);
				gflags.push_back(facc);
			end
		end
	end
	task automatic send_beat(input logic [255:0] d, input logic en);
		logic inv;
		far_busy_n = 1'b0;
		far_oe = 1'b1;
		#20;
		for (int k = 0; k < 4; k++) begin
			for (int g = 0; g < 4; g++) begin
				inv = en && $countones(d[64*k+16*g+:16]) > 8;
				far_data_n[16*g+:16] = inv ? d[64*k+16*g+:16]
					: ~d[64*k+16*g+:16];
				far_flag_n[g] = !inv;
			end
			#10;
			far_pos_n = {4{k[0]}};
			far_neg_n = {4{~k[0]}};
			#30;
		end
		far_pos_n = '1;
		far_neg_n = '1;
		far_oe = 1'b0;
		far_busy_n = 1'b1;
	endtask : send_beat
endmodule : far_agent_model

// file: dv/quad_pumped_data_bus_inversion_test.sv
// self-checking bench for the quad-pumped bus endpoint
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module quad_pumped_data_bus_inversion_test
	import qp_dbi_pkg::*;
;
	localparam logic [63:0] W = 64'hffff_00ff_fe01_1234;
	logic core_clk = 0, rstn = 1, tx_valid = 0, tx_inv_en = 0;
	logic common_clk;
	logic [255:0] tx_data = '0, rx_data;
	logic [15:0] rx_flags;
	int fail_count = 0, checks = 0;
	logic tx_ready, rx_valid, d_oe, f_oe, s_oe, b_o, b_oe, far_busy_n, far_oe;
	logic [63:0] d_o, far_data_n, data_w;
	logic [3:0] f_o, p_o, n_o, far_flag_n, far_pos_n, far_neg_n;
	logic [3:0] flag_w, pos_w, neg_w;
	logic busy_w;
	// released lines rest high on their pull-ups
	assign data_w = (d_oe ? d_o : '1) & (far_oe ? far_data_n : '1);
	assign flag_w = (f_oe ? f_o : '1) & (far_oe ? far_flag_n : '1);
	assign pos_w = (s_oe ? p_o : '1) & (far_oe ? far_pos_n : '1);
	assign neg_w = (s_oe ? n_o : '1) & (far_oe ? far_neg_n : '1);
	assign busy_w = (b_oe ? b_o : 1'b1) & far_busy_n;
	always #10 core_clk = ~core_clk;
	quad_pumped_data_bus_inversion dut_u (.CORE_CLK(core_clk), .RSTN(rstn),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
		.TX_INV_EN(tx_inv_en), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.RX_FLAGS(rx_flags), .DATA_N_I(data_w), .DATA_N_O(d_o),
		.DATA_N_OE(d_oe), .GROUP_INVERT_FLAG_N_I(flag_w),
		.GROUP_INVERT_FLAG_N_O(f_o), .GROUP_INVERT_FLAG_N_OE(f_oe),
		.DATA_STROBE_POS_N_I(pos_w), .DATA_STROBE_NEG_N_I(neg_w),
		.DATA_STROBE_POS_N_O(p_o), .DATA_STROBE_NEG_N_O(n_o),
		.DATA_STROBE_N_OE(s_oe), .DATA_LINES_IN_USE_N_I(busy_w),
		.DATA_LINES_IN_USE_N_O(b_o), .DATA_LINES_IN_USE_N_OE(b_oe),
		.COMMON_CLK_O(common_clk));
	far_agent_model agent_u (.data_n(data_w), .flag_n(flag_w), .pos_n(pos_w),
		.neg_n(neg_w), .far_data_n(far_data_n), .far_flag_n(far_flag_n),
		.far_pos_n(far_pos_n), .far_neg_n(far_neg_n),
		.far_busy_n(far_busy_n), .far_oe(far_oe));
	task automatic final_report;
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic take_beat(input logic [255:0] d, input logic en);
		int n;
		tx_valid = 1'b1;
		tx_data = d;
		tx_inv_en = en;
		for (n = 0; n < 20 && tx_ready !== 1'b1; n++)
			@(negedge core_clk);
		`CHK(tx_ready, 1'b1)
		`CHK(common_clk, 1'b0)
		@(posedge core_clk);
		#1;
		`CHK(common_clk, 1'b1)
	endtask : take_beat
	// two beats with no gap, inversion off then on
	task automatic send_back_to_back;
		take_beat({~W, W, ~W, W}, 1'b0);
		take_beat({~W, W, ~W, W}, 1'b1);
		tx_valid = 1'b0;
		repeat (16) @(posedge core_clk);
		#1;
		`CHK(agent_u.got.size(), 2)
		`CHK(agent_u.got[0], {~W, W, ~W, W})
		`CHK(agent_u.gflags[0], 16'h0000)
		`CHK(agent_u.got[1], {~W, W, ~W, W})
		`CHK(agent_u.gflags[1], 16'h1818)
	endtask : send_back_to_back
	// far side owns the lines; a pending beat must wait
	task automatic receive_beat;
		int n;
		fork
			agent_u.send_beat({W, ~W, ~W, W}, 1'b1);
			begin
				repeat (3) @(posedge core_clk);
				#1;
				tx_valid = 1'b1;
				// held across a period end while the far side is busy
				repeat (6) begin
					@(negedge core_clk);
					`CHK(d_oe, 1'b0)
					`CHK(tx_ready, 1'b0)
				end
				@(posedge core_clk);
				#1;
				tx_valid = 1'b0;
			end
		join
		for (n = 0; n < 20 && rx_valid !== 1'b1; n++)
			@(negedge core_clk);
		`CHK(rx_valid, 1'b1)
		`CHK(rx_data, {W, ~W, ~W, W})
		`CHK(rx_flags, 16'h8118)
	endtask : receive_beat
	initial begin
		// a real falling edge, so the strobe-clocked capture resets too
		#1;
		rstn = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		send_back_to_back();
		receive_beat();
		final_report();
	end
	// whole run is near 39 cycles; this limit is generous
	initial begin
		#20000;
		fail_count++;
		final_report();
	end
endmodule : quad_pumped_data_bus_inversion_test
